// File: hdl/ctac_central_terminal_amp_config.sv
// Functional notes
// - An 8-bit register at address 19h holds amp C power (bit 7), amp B power (bit 6), B select (5:3), C select (2:0).
// - A cleared power bit keeps its amplifier off and is the reset state; a set bit powers it on.
// - The B select field connects exactly one of the eight channel 1-4 electrode inputs to amplifier B.
// - The B select field resets to 010, channel 2 positive.
// - The C select field connects exactly one of the eight channel 1-4 electrode inputs to amplifier C.
// - The C select field resets to 100, channel 3 positive.
// - Select codes map as (upper two bits = channel minus one, low bit = negative side).
// - A channel mux code of 110 routes the bias-drive return to its positive side, 111 to its negative side.
// - Amplifier A uses the same select encoding, its field lives in a companion register and resets to 000.
`timescale 1ns/1ps
`default_nettype none

module ctac_central_terminal_amp_config
  import ctac_pkg::*;
#(
  parameter int NUM_CH = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire ctac_wr_s reg_wr,
  input wire logic [7:0] reg_rd_addr,
  input wire logic [2:0] amp_a_input_select,
  input wire logic [NUM_CH*CTAC_CH_MUX_W-1:0] channel_input_select,
  output logic [7:0] reg_rd_data,
  output logic amp_b_power_on,
  output logic amp_c_power_on,
  output logic [7:0] amp_a_electrode_en,
  output logic [7:0] amp_b_electrode_en,
  output logic [7:0] amp_c_electrode_en,
  output var ctac_bias_route_s [NUM_CH-1:0] bias_drive_route
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // One-hot electrode enable; bit 2*(ch-1)+neg, so the code is the index.
  function automatic logic [7:0] sel_onehot(input logic [2:0] code);
    sel_onehot = 8'h01 << code;
  endfunction

  logic [7:0] sel_bc_q;
  logic [7:0] sel_bc_d;
  logic wr_hit;

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Only a write that hits our address changes the register.
  assign wr_hit = reg_wr.en && (reg_wr.addr == CTAC_ADDR_SEL_BC);
  assign sel_bc_d = wr_hit ? reg_wr.data : sel_bc_q;

  // Storage with its documented composite reset value.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_bc_q <= CTAC_SEL_BC_RST;
    end else begin
      sel_bc_q <= sel_bc_d;
    end
  end

  // Read back; unmapped addresses read as zero.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else begin
      reg_rd_data <= (reg_rd_addr == CTAC_ADDR_SEL_BC) ? sel_bc_q : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Analog steering
  // ----------------------------------------------------------------
  // Registered so analog switches see glitch-free levels. The switches
  // follow the register one cycle late, which software never notices.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      amp_b_power_on <= 1'b0;
      amp_c_power_on <= 1'b0;
      amp_b_electrode_en <= sel_onehot(CTAC_B_SEL_RST);
      amp_c_electrode_en <= sel_onehot(CTAC_C_SEL_RST);
      amp_a_electrode_en <= sel_onehot(CTAC_A_SEL_RST);
    end else begin
      amp_c_power_on <= sel_bc_q[CTAC_C_PWR_BIT];
      amp_b_power_on <= sel_bc_q[CTAC_B_PWR_BIT];
      amp_b_electrode_en <= sel_onehot(sel_bc_q[CTAC_B_SEL_LSB +: CTAC_SEL_W]);
      amp_c_electrode_en <= sel_onehot(sel_bc_q[CTAC_C_SEL_LSB +: CTAC_SEL_W]);
      amp_a_electrode_en <= sel_onehot(amp_a_input_select);
    end
  end

  // Bias-drive return rerouting per channel. Host keeps such channels
  // out of measurement; the block does not police that.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bias_drive_route <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        bias_drive_route[i].pos <= channel_input_select[i*3 +: 3] == CTAC_MUX_BIAS_POS;
        bias_drive_route[i].neg <= channel_input_select[i*3 +: 3] == CTAC_MUX_BIAS_NEG;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  wr_takes_a: assert property (wr_hit |=> sel_bc_q == $past(reg_wr.data))
    else $error("write to config register not stored");
  no_stray_wr_a: assert property (!wr_hit |=> $stable(sel_bc_q))
    else $error("config register changed without a write");
  rst_value_a: assert property ($fell(sys_rst) |-> sel_bc_q == 8'h14)
    else $error("bad composite reset value");
  rst_pwr_a: assert property ($fell(sys_rst) |-> !amp_b_power_on && !amp_c_power_on)
    else $error("amplifier powered at reset");
  pwr_c_follow_a: assert property (wr_hit ##1 1'b1 |=> amp_c_power_on == $past(reg_wr.data[7], 2))
    else $error("amp C power does not follow bit 7");
  pwr_b_follow_a: assert property (wr_hit ##1 1'b1 |=> amp_b_power_on == $past(reg_wr.data[6], 2))
    else $error("amp B power does not follow bit 6");
  b_onehot_a: assert property ($onehot(amp_b_electrode_en))
    else $error("amp B not exactly one electrode");
  c_onehot_a: assert property ($onehot(amp_c_electrode_en))
    else $error("amp C not exactly one electrode");
  b_rst_sel_a: assert property ($fell(sys_rst) |-> amp_b_electrode_en == 8'h04)
    else $error("amp B reset selection wrong");
  c_rst_sel_a: assert property ($fell(sys_rst) |-> amp_c_electrode_en == 8'h10)
    else $error("amp C reset selection wrong");
  b_map_a: assert property (wr_hit ##1 1'b1 |=> amp_b_electrode_en[$past(reg_wr.data[5:3], 2)])
    else $error("amp B electrode mapping wrong");
  a_map_a: assert property (1'b1 |=> amp_a_electrode_en[$past(amp_a_input_select)])
    else $error("amp A electrode mapping wrong");
  bias_pos_a: assert property (channel_input_select[2:0] == 3'h6 |=> bias_drive_route[0].pos && !bias_drive_route[0].neg)
    else $error("bias return not on positive side");

  // Amplifier C mapping mirrors amplifier B, two cycles after the write
  // because the steering flops sit behind the register.
  c_map_a: assert property (wr_hit ##1 1'b1 |=> amp_c_electrode_en[$past(reg_wr.data[2:0], 2)])
    else $error("amp C electrode mapping wrong");

  // Read port: the register for its own address, zero for all others.
  rd_data_a: assert property (reg_rd_addr == CTAC_ADDR_SEL_BC |=> reg_rd_data == $past(sel_bc_q))
    else $error("read data does not show the register");

  rd_zero_a: assert property (reg_rd_addr != CTAC_ADDR_SEL_BC |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");

  rd_rst_a: assert property ($fell(sys_rst) |-> reg_rd_data == 8'h00)
    else $error("read data not cleared by reset");

  // Amplifier A follows its companion field with the same encoding.
  a_rst_sel_a: assert property ($fell(sys_rst) |-> amp_a_electrode_en == 8'h01)
    else $error("amp A reset selection wrong");

  a_onehot_a: assert property ($onehot(amp_a_electrode_en))
    else $error("amp A not exactly one electrode");

  // Without a write the power switches must not move; a glitch here
  // would briefly wake or kill an amplifier.
  pwr_c_hold_a: assert property (!wr_hit ##1 !wr_hit |=> $stable(amp_c_power_on))
    else $error("amp C power moved without a write");

  pwr_b_hold_a: assert property (!wr_hit ##1 !wr_hit |=> $stable(amp_b_power_on))
    else $error("amp B power moved without a write");

  // Bias-drive return routing, one pair of checks per channel.
  bias_neg_a: assert property (channel_input_select[2:0] == 3'h7 |=> bias_drive_route[0].neg)
    else $error("bias return not on negative side");

  bias_pos1_a: assert property (channel_input_select[5:3] == 3'h6 |=> bias_drive_route[1].pos)
    else $error("channel 2 bias return not on positive side");

  bias_neg1_a: assert property (channel_input_select[5:3] == 3'h7 |=> bias_drive_route[1].neg)
    else $error("channel 2 bias return not on negative side");

  bias_pos2_a: assert property (channel_input_select[8:6] == 3'h6 |=> bias_drive_route[2].pos)
    else $error("channel 3 bias return not on positive side");

  bias_neg2_a: assert property (channel_input_select[8:6] == 3'h7 |=> bias_drive_route[2].neg)
    else $error("channel 3 bias return not on negative side");

  bias_pos3_a: assert property (channel_input_select[11:9] == 3'h6 |=> bias_drive_route[3].pos)
    else $error("channel 4 bias return not on positive side");

  bias_neg3_a: assert property (channel_input_select[11:9] == 3'h7 |=> bias_drive_route[3].neg)
    else $error("channel 4 bias return not on negative side");

  // Ordinary codes must leave the return disconnected.
  bias_off_a: assert property (!(channel_input_select[2:0] inside {3'h6, 3'h7}) |=> bias_drive_route[0] == 2'b00)
    else $error("bias return routed without its code");

  // Both sides at once would short the return across the channel.
  bias_excl0_a: assert property (!(bias_drive_route[0].pos && bias_drive_route[0].neg))
    else $error("channel 1 bias return on both sides");

  bias_excl1_a: assert property (!(bias_drive_route[1].pos && bias_drive_route[1].neg))
    else $error("channel 2 bias return on both sides");

  bias_excl2_a: assert property (!(bias_drive_route[2].pos && bias_drive_route[2].neg))
    else $error("channel 3 bias return on both sides");

  bias_excl3_a: assert property (!(bias_drive_route[3].pos && bias_drive_route[3].neg))
    else $error("channel 4 bias return on both sides");

  // Main scenarios that the bench should reach.

  cov_b_pwr_c: cover property (wr_hit && reg_wr.data[6]);
  cov_both_pwr_c: cover property (amp_b_power_on && amp_c_power_on);
  cov_bias_neg_c: cover property (bias_drive_route[0].neg);
  cov_bias_pos_c: cover property (bias_drive_route[3].pos);
  cov_stray_wr_c: cover property (reg_wr.en && reg_wr.addr != CTAC_ADDR_SEL_BC);

endmodule // ctac_central_terminal_amp_config

`default_nettype wire

// File: hdl/ctac_pkg.sv
package ctac_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTAC_ADDR_SEL_BC = 8'h19;
  localparam int CTAC_REG_W = 8;
  localparam int CTAC_SEL_W = 3;
  localparam int CTAC_CH_MUX_W = 3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTAC_C_PWR_BIT = 7;
  localparam int CTAC_B_PWR_BIT = 6;
  localparam int CTAC_B_SEL_LSB = 3;
  localparam int CTAC_C_SEL_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CTAC_B_SEL_RST = 3'h2;
  localparam logic [2:0] CTAC_C_SEL_RST = 3'h4;
  localparam logic [2:0] CTAC_A_SEL_RST = 3'h0;
  localparam logic [7:0] CTAC_SEL_BC_RST = {1'b0, 1'b0, CTAC_B_SEL_RST, CTAC_C_SEL_RST};

  // ----------------------------------------------------------------
  // Channel input multiplexer codes that reroute the bias-drive return
  // ----------------------------------------------------------------
  localparam logic [2:0] CTAC_MUX_BIAS_POS = 3'h6;
  localparam logic [2:0] CTAC_MUX_BIAS_NEG = 3'h7;

  // Register write request from the serial front end.
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } ctac_wr_s;

  // Routing of the bias-drive return onto one channel input side.
  typedef struct packed {
    logic pos;
    logic neg;
  } ctac_bias_route_s;

endpackage

// File: test/ctac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctac_host_model
  import ctac_pkg::*;
(
  input wire logic ref_clk,
  output var ctac_wr_s reg_wr,
  output var logic [7:0] reg_rd_addr
);
  // Idle host: no write pending, reading the configuration register.
  initial begin
    reg_wr = '0;
    reg_rd_addr = 8'h19;
  end
  // One write per call; the strobe drops at the next edge so no write repeats.
  // Rerouted bias-drive channels are never read back for measurement.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= '{en: 1'b1, addr: a, data: d};
    @(posedge ref_clk);
    reg_wr.en <= 1'b0;
  endtask
  // Move the read address at a rising edge.
  task automatic ra(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd_addr <= a;
  endtask
endmodule // ctac_host_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ctac_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  ctac_wr_s reg_wr;
  logic [7:0] reg_rd_addr, reg_rd_data, a_en, b_en, c_en;
  logic [2:0] a_sel = 3'h0;
  logic [11:0] ch_sel = 12'h000;
  logic b_pwr, c_pwr;
  ctac_bias_route_s [3:0] route;
  int n_fail = 0, checks = 0, cyc = 0;
  // ----------------------------------------------------------------
  // Clock, hang guard and instances
  // ----------------------------------------------------------------
  initial forever #2.5 ref_clk = ~ref_clk;
  // The tests need under a hundred cycles, so 2000 means a hang.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end
  ctac_host_model ctac_host_model_inst (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr));
  ctac_central_terminal_amp_config #(.NUM_CH(4)) ctac_central_terminal_amp_config_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr), .amp_a_input_select(a_sel),
    .channel_input_select(ch_sel), .reg_rd_data(reg_rd_data), .amp_b_power_on(b_pwr), .amp_c_power_on(c_pwr),
    .amp_a_electrode_en(a_en), .amp_b_electrode_en(b_en), .amp_c_electrode_en(c_en), .bias_drive_route(route));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register then steering outputs need two edges; a third gives margin.
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    chk(reg_rd_data, 8'h14);
    chk({6'h0, c_pwr, b_pwr}, 8'h00);
    chk(b_en, 8'h04);
    chk(c_en, 8'h10);
    chk(a_en, 8'h01);
    chk(route, 8'h00);
    $display("test_reset done");
  endtask
  // Back-to-back codes sweep both selects in opposite directions.
  task automatic test_codes();
    logic [2:0] s;
    for (int k = 0; k < 8; k++) begin
      s = k[2:0];
      ctac_host_model_inst.wr(8'h19, {s[0], ~s[0], s, 3'h7 - s});
      settle();
      chk(reg_rd_data, {s[0], ~s[0], s, 3'h7 - s});
      chk({6'h0, c_pwr, b_pwr}, {6'h0, s[0], ~s[0]});
      chk(b_en, 8'h01 << s);
      chk(c_en, 8'h80 >> s);
    end
    $display("test_codes done");
  endtask
  // A write to the neighbouring address must leave the register alone.
  task automatic test_unmapped();
    ctac_host_model_inst.wr(8'h18, 8'hff);
    settle();
    chk(reg_rd_data, 8'hb8);
    ctac_host_model_inst.ra(8'h18);
    settle();
    chk(reg_rd_data, 8'h00);
    ctac_host_model_inst.ra(8'h19);
    $display("test_unmapped done");
  endtask
  task automatic test_mux();
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      ch_sel <= 12'(6 + i % 2) << (3 * (i / 2));
      a_sel <= 3'(i);
      settle();
      chk(route, 8'(2 - i % 2) << (2 * (i / 2)));
      chk(a_en, 8'h01 << i);
    end
    $display("test_mux done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle();
    test_reset();
    test_codes();
    test_unmapped();
    test_mux();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
